// [gcf_pkg.sv]
// Constants shared by the clear, flash command and temperature register group.
// Assumes a 100 MHz mclk and an 8-bit register address space.
package gcf_pkg;

	// --------------------------------------------------------------
	// Register addresses
	// --------------------------------------------------------------
	localparam logic [7:0] ADDR_TEMP_LOW = 8'h60;
	localparam logic [7:0] ADDR_TEMP_HIGH = 8'h61;
	localparam logic [7:0] ADDR_FLASH_COMMAND = 8'h62;
	localparam logic [7:0] ADDR_COUNTER_CLEAR = 8'h63;
	localparam logic [7:0] ADDR_PROGRAM_DATA = 8'h6f;
	localparam logic [7:0] ADDR_PROGRAM_ADDRESS = 8'h70;
	localparam logic [7:0] ADDR_SHADOW_FIRST = 8'h75;
	localparam logic [7:0] ADDR_SHADOW_LAST = 8'h77;
	localparam logic [7:0] ADDR_FLASH_LAST = 8'h5f;
	localparam logic [7:0] ADDR_RAM_BASE = 8'h80;
	localparam logic [7:0] ADDR_RAM_LAST = 8'h9f;

	// --------------------------------------------------------------
	// Counter clear control fields and reset values
	// --------------------------------------------------------------
	localparam int BIT_CLEAR_DISCHARGE_COUNT = 0;
	localparam int BIT_CLEAR_CHARGE_COUNT = 1;
	localparam int BIT_CLEAR_SELF_DISCHARGE = 2;
	localparam int BIT_CLEAR_DISCHARGE_TIME = 3;
	localparam int BIT_CLEAR_CHARGE_TIME = 4;
	localparam int BIT_STATUS_PIN = 5;
	localparam int BIT_RESET_FLAG = 6;
	localparam int BIT_RESERVED_TOP = 7;
	localparam int CLEAR_BITS = 5;
	localparam logic [7:0] COUNTER_CLEAR_RESET = 8'h60;
	localparam logic [7:0] PROGRAM_REG_RESET = 8'h00;
	localparam logic [6:0] TEMP_HIGH_UPPER = 7'h00;

	// --------------------------------------------------------------
	// Flash command codes
	// --------------------------------------------------------------
	localparam logic [7:0] CMD_NONE = 8'h00;
	localparam logic [7:0] CMD_PROGRAM_BYTE = 8'h0f;
	localparam logic [7:0] CMD_ERASE_PAGE0 = 8'h40;
	localparam logic [7:0] CMD_ERASE_PAGE1 = 8'h41;
	localparam logic [7:0] CMD_ERASE_PAGE2 = 8'h42;
	localparam logic [7:0] CMD_ERASE_SHADOW = 8'h43;
	localparam logic [7:0] CMD_RAM_TO_FLASH = 8'h45;
	localparam logic [7:0] CMD_FLASH_TO_RAM = 8'h48;
	localparam logic [7:0] CMD_POWER_DOWN = 8'hf6;
	localparam logic [7:0] CMD_CAL_POWER_DOWN = 8'hf7;

	// --------------------------------------------------------------
	// Flash layout
	// --------------------------------------------------------------
	localparam int FLASH_BYTES = 99;
	localparam int FLASH_AW = 7;
	localparam logic [6:0] PAGE0_BASE = 7'h00;
	localparam logic [6:0] PAGE1_BASE = 7'h20;
	localparam logic [6:0] PAGE2_BASE = 7'h40;
	localparam logic [6:0] SHADOW_BASE = 7'h60;
	localparam logic [5:0] PAGE_BYTES = 6'h20;
	localparam logic [5:0] SHADOW_BYTES = 6'h03;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam int RAM_BYTES = 32;

	// --------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int CAL_TIME_US = 20;
	localparam int CAL_CYCLES =
		(CAL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// [gcf_link_if.sv]
// Carrier between the register group, its flash store and power control.
// Assumes all three parties run on the same mclk.
`timescale 1ns/1ps
interface gcf_link_if;
	logic flashWrEn;
	logic [6:0] flashWrAddr;
	logic [7:0] flashWrData;
	logic [6:0] hostRdAddr;
	logic [7:0] hostRdData;
	logic [6:0] seqRdAddr;
	logic [7:0] seqRdData;
	logic sleepReq;
	logic calReq;
	logic powerDone;
	logic sleeping;
	logic calibrating;

	modport ctrl(
		output flashWrEn, flashWrAddr, flashWrData, hostRdAddr, seqRdAddr,
		output sleepReq, calReq,
		input hostRdData, seqRdData, powerDone, sleeping, calibrating
	);
	modport store(
		input flashWrEn, flashWrAddr, flashWrData, hostRdAddr, seqRdAddr,
		output hostRdData, seqRdData
	);
	modport power(
		input sleepReq, calReq,
		output powerDone, sleeping, calibrating
	);
endinterface

// [gcf_flash_store.sv]
// Nonvolatile byte store: three pages plus the offset shadow bytes.
// Assumes one write per cycle; contents are not touched by reset.
`timescale 1ns/1ps
module gcf_flash_store (
	input wire logic mclk,
	gcf_link_if.store link
);
	logic [7:0] mem [gcf_pkg::FLASH_BYTES];

	// --------------------------------------------------------------
	// Write port and two read ports
	// --------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (link.flashWrEn) begin
			mem[link.flashWrAddr] <= link.flashWrData;
		end
	end

	assign link.hostRdData = mem[link.hostRdAddr];
	assign link.seqRdData = mem[link.seqRdAddr];
endmodule

// [gcf_power_ctrl.sv]
// Sleep and calibrate-then-sleep sequencing for the power commands.
// Assumes sleepAllowed and lineEdge are already on the mclk domain.
`timescale 1ns/1ps
module gcf_power_ctrl #(
	parameter int CAL_CYCLES = gcf_pkg::CAL_CYCLES
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic sleepAllowed,
	input wire logic lineEdge,
	gcf_link_if.power link
);
	localparam int CW = $clog2(CAL_CYCLES + 1);

	typedef enum logic [5:0] {
		PW_IDLE = 6'b000001,
		PW_WAIT_CAL = 6'b000010,
		PW_CAL = 6'b000100,
		PW_WAIT_SLEEP = 6'b001000,
		PW_SLEEP = 6'b010000,
		PW_DONE = 6'b100000
	} gcf_pw_state_t;

	typedef struct packed {
		gcf_pw_state_t state;
		logic [CW-1:0] count;
		logic aborted;
	} gcf_pw_regs_t;

	gcf_pw_regs_t st_reg;
	gcf_pw_regs_t st_next;

	// --------------------------------------------------------------
	// Sequencer
	// --------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		case (st_reg.state)
			PW_IDLE: begin
				if (link.calReq) begin
					st_next.state = PW_WAIT_CAL;
				end else if (link.sleepReq) begin
					st_next.state = PW_WAIT_SLEEP;
				end
			end
			PW_WAIT_CAL: begin
				if (lineEdge) begin
					st_next.state = PW_DONE;
				end else if (sleepAllowed) begin
					st_next.state = PW_CAL;
					st_next.count = '0;
					st_next.aborted = 1'b0;
				end
			end
			PW_CAL: begin
				st_next.count = st_reg.count + CW'(1);
				if (lineEdge) begin
					st_next.aborted = 1'b1;
				end
				if (st_reg.count == CW'(CAL_CYCLES - 1)) begin
					if (st_reg.aborted || lineEdge) begin
						st_next.state = PW_DONE;
					end else begin
						st_next.state = PW_WAIT_SLEEP;
					end
				end
			end
			PW_WAIT_SLEEP: begin
				if (lineEdge) begin
					st_next.state = PW_DONE;
				end else if (sleepAllowed) begin
					st_next.state = PW_SLEEP;
				end
			end
			PW_SLEEP: begin
				if (lineEdge) begin
					st_next.state = PW_DONE;
				end
			end
			PW_DONE: begin
				st_next.state = PW_IDLE;
			end
			default: begin
				st_next.state = PW_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '{state: PW_IDLE, count: '0, aborted: 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign link.powerDone = (st_reg.state == PW_DONE);
	assign link.sleeping = (st_reg.state == PW_SLEEP);
	assign link.calibrating = (st_reg.state == PW_CAL);
endmodule

// [gcf_control_regs.sv]
// Counter clear, flash command and temperature registers of the gauge.
// Assumes a byte-wide register port from the serial link logic on mclk,
// and raw sensor, supply and serial line levels arriving from pins.
`timescale 1ns/1ps

module gcf_control_regs #(
	parameter int CAL_CYCLES = gcf_pkg::CAL_CYCLES
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	output logic regRdValid,
	input wire logic [8:0] tempSense,
	input wire logic senseBelowWake,
	input wire logic [2:0] wakeEnableBits,
	input wire logic porDetect,
	input wire logic hostLine,
	output logic statusPinOut,
	output logic statusPinOe,
	output logic clearChargeTime,
	output logic clearDischargeTime,
	output logic clearSelfDischarge,
	output logic clearChargeCount,
	output logic clearDischargeCount,
	output logic cmdBusy,
	output logic sleeping,
	output logic calibrating
);
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_PROGRAM = 5'b00010,
		ST_SWEEP = 5'b00100,
		ST_POWER = 5'b01000,
		ST_FINISH = 5'b10000
	} gcf_state_t;

	typedef enum logic [1:0] {
		SW_ERASE = 2'b00,
		SW_RAM_TO_FLASH = 2'b01,
		SW_FLASH_TO_RAM = 2'b10
	} gcf_sweep_t;

	typedef struct packed {
		gcf_state_t state;
		gcf_sweep_t sweepMode;
		logic [6:0] sweepBase;
		logic [5:0] sweepLen;
		logic [5:0] sweepIdx;
		logic [7:0] counterClear;
		logic [4:0] clearPulse;
		logic [7:0] flashCommand;
		logic [7:0] programAddr;
		logic [7:0] programData;
		logic [8:0] tempMeta;
		logic [8:0] tempSync;
		logic porMeta;
		logic porSync;
		logic senseMeta;
		logic senseSync;
		logic lineMeta;
		logic lineSync;
		logic linePrev;
		logic sleepReq;
		logic calReq;
		logic [7:0] rdData;
		logic rdValid;
	} gcf_regs_t;

	gcf_regs_t st_reg;
	gcf_regs_t st_next;

	gcf_link_if link();

	logic [7:0] ram [gcf_pkg::RAM_BYTES];
	logic ramWe;
	logic [4:0] ramWrAddr;
	logic [7:0] ramWrData;
	logic [7:0] ramHostRd;
	logic [7:0] ramSeqRd;
	logic sleepAllowed;
	logic lineEdge;
	logic [7:0] rdMux;
	logic hostWr;

	// --------------------------------------------------------------
	// Submodules
	// --------------------------------------------------------------
	gcf_flash_store u_flash (
		.mclk(mclk),
		.link(link.store)
	);

	gcf_power_ctrl #(
		.CAL_CYCLES(CAL_CYCLES)
	) u_power (
		.mclk(mclk),
		.resetn(resetn),
		.sleepAllowed(sleepAllowed),
		.lineEdge(lineEdge),
		.link(link.power)
	);

	// --------------------------------------------------------------
	// General RAM
	// --------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (ramWe) begin
			ram[ramWrAddr] <= ramWrData;
		end
	end

	assign ramHostRd = ram[regAddr[4:0]];
	assign ramSeqRd = ram[st_reg.sweepIdx[4:0]];

	assign sleepAllowed = (wakeEnableBits == 3'h0) || st_reg.senseSync;
	assign lineEdge = st_reg.lineSync ^ st_reg.linePrev;
	assign hostWr = regWrEn;

	// --------------------------------------------------------------
	// Host read address into flash
	// --------------------------------------------------------------
	always_comb begin
		if (regAddr >= gcf_pkg::ADDR_SHADOW_FIRST &&
				regAddr <= gcf_pkg::ADDR_SHADOW_LAST) begin
			link.hostRdAddr = gcf_pkg::SHADOW_BASE +
				7'(regAddr - gcf_pkg::ADDR_SHADOW_FIRST);
		end else begin
			link.hostRdAddr = regAddr[6:0];
		end
	end

	// --------------------------------------------------------------
	// Read data mux
	// --------------------------------------------------------------
	always_comb begin
		rdMux = 8'h00;
		if (regAddr <= gcf_pkg::ADDR_FLASH_LAST) begin
			rdMux = link.hostRdData;
		end else if (regAddr >= gcf_pkg::ADDR_SHADOW_FIRST &&
				regAddr <= gcf_pkg::ADDR_SHADOW_LAST) begin
			rdMux = link.hostRdData;
		end else if (regAddr >= gcf_pkg::ADDR_RAM_BASE &&
				regAddr <= gcf_pkg::ADDR_RAM_LAST) begin
			rdMux = ramHostRd;
		end else begin
			case (regAddr)
				gcf_pkg::ADDR_TEMP_LOW: rdMux = st_reg.tempSync[7:0];
				gcf_pkg::ADDR_TEMP_HIGH: begin
					rdMux = {gcf_pkg::TEMP_HIGH_UPPER, st_reg.tempSync[8]};
				end
				gcf_pkg::ADDR_FLASH_COMMAND: rdMux = st_reg.flashCommand;
				gcf_pkg::ADDR_COUNTER_CLEAR: rdMux = st_reg.counterClear;
				gcf_pkg::ADDR_PROGRAM_DATA: rdMux = st_reg.programData;
				gcf_pkg::ADDR_PROGRAM_ADDRESS: rdMux = st_reg.programAddr;
				default: rdMux = 8'h00;
			endcase
		end
	end

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		link.flashWrEn = 1'b0;
		link.flashWrAddr = 7'h00;
		link.flashWrData = gcf_pkg::ERASED_BYTE;
		link.seqRdAddr = st_reg.programAddr[6:0];
		ramWe = 1'b0;
		ramWrAddr = regAddr[4:0];
		ramWrData = regWrData;

		// Pin synchronisers
		st_next.tempMeta = tempSense;
		st_next.tempSync = st_reg.tempMeta;
		st_next.porMeta = porDetect;
		st_next.porSync = st_reg.porMeta;
		st_next.senseMeta = senseBelowWake;
		st_next.senseSync = st_reg.senseMeta;
		st_next.lineMeta = hostLine;
		st_next.lineSync = st_reg.lineMeta;
		st_next.linePrev = st_reg.lineSync;

		// Read response
		st_next.rdValid = regRdEn;
		if (regRdEn) begin
			st_next.rdData = rdMux;
		end

		// Clear bits become one-cycle pulses, then self-clear
		st_next.clearPulse = st_reg.counterClear[gcf_pkg::CLEAR_BITS-1:0];
		st_next.counterClear[gcf_pkg::CLEAR_BITS-1:0] = '0;

		st_next.sleepReq = 1'b0;
		st_next.calReq = 1'b0;

		// Host writes
		if (hostWr) begin
			case (regAddr)
				gcf_pkg::ADDR_COUNTER_CLEAR: begin
					st_next.counterClear[gcf_pkg::CLEAR_BITS-1:0] =
						regWrData[gcf_pkg::CLEAR_BITS-1:0];
					st_next.counterClear[gcf_pkg::BIT_STATUS_PIN] =
						regWrData[gcf_pkg::BIT_STATUS_PIN];
					st_next.counterClear[gcf_pkg::BIT_RESET_FLAG] =
						regWrData[gcf_pkg::BIT_RESET_FLAG];
					st_next.counterClear[gcf_pkg::BIT_RESERVED_TOP] =
						regWrData[gcf_pkg::BIT_RESERVED_TOP];
				end
				gcf_pkg::ADDR_FLASH_COMMAND: begin
					if (st_reg.state == ST_IDLE &&
							st_reg.flashCommand == gcf_pkg::CMD_NONE) begin
						st_next.flashCommand = regWrData;
					end
				end
				gcf_pkg::ADDR_PROGRAM_DATA: st_next.programData = regWrData;
				gcf_pkg::ADDR_PROGRAM_ADDRESS: st_next.programAddr = regWrData;
				default: begin
					if (regAddr >= gcf_pkg::ADDR_RAM_BASE &&
							regAddr <= gcf_pkg::ADDR_RAM_LAST) begin
						ramWe = 1'b1;
					end
				end
			endcase
		end

		// Supply loss wins over a host clear
		if (st_reg.porSync) begin
			st_next.counterClear[gcf_pkg::BIT_RESET_FLAG] = 1'b1;
		end

		// Command sequencer
		case (st_reg.state)
			ST_IDLE: begin
				st_next.sweepIdx = 6'h00;
				st_next.sweepLen = gcf_pkg::PAGE_BYTES;
				st_next.sweepMode = SW_ERASE;
				case (st_reg.flashCommand)
					gcf_pkg::CMD_NONE: st_next.state = ST_IDLE;
					gcf_pkg::CMD_PROGRAM_BYTE: st_next.state = ST_PROGRAM;
					gcf_pkg::CMD_ERASE_PAGE0: begin
						st_next.sweepBase = gcf_pkg::PAGE0_BASE;
						st_next.state = ST_SWEEP;
					end
					gcf_pkg::CMD_ERASE_PAGE1: begin
						st_next.sweepBase = gcf_pkg::PAGE1_BASE;
						st_next.state = ST_SWEEP;
					end
					gcf_pkg::CMD_ERASE_PAGE2: begin
						st_next.sweepBase = gcf_pkg::PAGE2_BASE;
						st_next.state = ST_SWEEP;
					end
					gcf_pkg::CMD_ERASE_SHADOW: begin
						st_next.sweepBase = gcf_pkg::SHADOW_BASE;
						st_next.sweepLen = gcf_pkg::SHADOW_BYTES;
						st_next.state = ST_SWEEP;
					end
					gcf_pkg::CMD_RAM_TO_FLASH: begin
						st_next.sweepBase = gcf_pkg::PAGE0_BASE;
						st_next.sweepMode = SW_RAM_TO_FLASH;
						st_next.state = ST_SWEEP;
					end
					gcf_pkg::CMD_FLASH_TO_RAM: begin
						st_next.sweepBase = gcf_pkg::PAGE0_BASE;
						st_next.sweepMode = SW_FLASH_TO_RAM;
						st_next.state = ST_SWEEP;
					end
					gcf_pkg::CMD_POWER_DOWN: begin
						st_next.sleepReq = 1'b1;
						st_next.state = ST_POWER;
					end
					gcf_pkg::CMD_CAL_POWER_DOWN: begin
						st_next.calReq = 1'b1;
						st_next.state = ST_POWER;
					end
					default: st_next.state = ST_FINISH;
				endcase
			end
			ST_PROGRAM: begin
				link.seqRdAddr = st_reg.programAddr[6:0];
				if (st_reg.programAddr <= gcf_pkg::ADDR_FLASH_LAST) begin
					link.flashWrEn = 1'b1;
					link.flashWrAddr = st_reg.programAddr[6:0];
					link.flashWrData = link.seqRdData & st_reg.programData;
				end
				st_next.state = ST_FINISH;
			end
			ST_SWEEP: begin
				link.seqRdAddr = st_reg.sweepBase + 7'(st_reg.sweepIdx);
				case (st_reg.sweepMode)
					SW_ERASE: begin
						link.flashWrEn = 1'b1;
						link.flashWrAddr = st_reg.sweepBase + 7'(st_reg.sweepIdx);
						link.flashWrData = gcf_pkg::ERASED_BYTE;
					end
					SW_RAM_TO_FLASH: begin
						link.flashWrEn = 1'b1;
						link.flashWrAddr = st_reg.sweepBase + 7'(st_reg.sweepIdx);
						link.flashWrData = ramSeqRd;
					end
					SW_FLASH_TO_RAM: begin
						ramWe = 1'b1;
						ramWrAddr = st_reg.sweepIdx[4:0];
						ramWrData = link.seqRdData;
					end
					default: begin
						link.flashWrEn = 1'b0;
					end
				endcase
				st_next.sweepIdx = st_reg.sweepIdx + 6'h01;
				if (st_reg.sweepIdx == st_reg.sweepLen - 6'h01) begin
					st_next.state = ST_FINISH;
				end
			end
			ST_POWER: begin
				if (link.powerDone) begin
					st_next.state = ST_FINISH;
				end
			end
			ST_FINISH: begin
				st_next.flashCommand = gcf_pkg::CMD_NONE;
				st_next.state = ST_IDLE;
			end
			default: begin
				st_next.state = ST_IDLE;
			end
		endcase
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			st_reg <= '{
				state: ST_IDLE,
				sweepMode: SW_ERASE,
				sweepBase: 7'h00,
				sweepLen: 6'h00,
				sweepIdx: 6'h00,
				counterClear: gcf_pkg::COUNTER_CLEAR_RESET,
				clearPulse: 5'h00,
				flashCommand: gcf_pkg::CMD_NONE,
				programAddr: gcf_pkg::PROGRAM_REG_RESET,
				programData: gcf_pkg::PROGRAM_REG_RESET,
				tempMeta: 9'h000,
				tempSync: 9'h000,
				porMeta: 1'b0,
				porSync: 1'b0,
				senseMeta: 1'b0,
				senseSync: 1'b0,
				lineMeta: 1'b1,
				lineSync: 1'b1,
				linePrev: 1'b1,
				sleepReq: 1'b0,
				calReq: 1'b0,
				rdData: 8'h00,
				rdValid: 1'b0
			};
		end else begin
			st_reg <= st_next;
		end
	end

	// --------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------
	assign link.sleepReq = st_reg.sleepReq;
	assign link.calReq = st_reg.calReq;
	assign regRdData = st_reg.rdData;
	assign regRdValid = st_reg.rdValid;
	assign statusPinOut = 1'b0;
	assign statusPinOe = ~st_reg.counterClear[gcf_pkg::BIT_STATUS_PIN];
	assign clearDischargeCount =
		st_reg.clearPulse[gcf_pkg::BIT_CLEAR_DISCHARGE_COUNT];
	assign clearChargeCount =
		st_reg.clearPulse[gcf_pkg::BIT_CLEAR_CHARGE_COUNT];
	assign clearSelfDischarge =
		st_reg.clearPulse[gcf_pkg::BIT_CLEAR_SELF_DISCHARGE];
	assign clearDischargeTime =
		st_reg.clearPulse[gcf_pkg::BIT_CLEAR_DISCHARGE_TIME];
	assign clearChargeTime =
		st_reg.clearPulse[gcf_pkg::BIT_CLEAR_CHARGE_TIME];
	assign cmdBusy = (st_reg.flashCommand != gcf_pkg::CMD_NONE);
	assign sleeping = link.sleeping;
	assign calibrating = link.calibrating;
endmodule

// [gcf_host_model.sv]
// Host side of the single-wire link: holds the line level.
// Assumes toggleReq is a one-cycle pulse from the bench.
`timescale 1ns/1ps
module gcf_host_model (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic toggleReq,
	output logic hostLine
);
	// ------------------------------------------------------------
	// Line level
	// ------------------------------------------------------------
	// Idle high under pull-up; stays quiet unless asked to move
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hostLine <= 1'b1;
		end else if (toggleReq) begin
			hostLine <= !hostLine;
		end
	end
endmodule

// [gcf_regs_props.sv]
// Checker for the clear, command and temperature register group.
// Bound to gcf_control_regs; sees only its ports.
`timescale 1ns/1ps
module gcf_regs_props #(
	parameter int CAL_CYCLES = 8
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic [7:0] regWrData,
	input wire logic regRdEn,
	input wire logic [7:0] regRdData,
	input wire logic hostLine,
	input wire logic statusPinOe,
	input wire logic clearChargeTime,
	input wire logic cmdBusy,
	input wire logic sleeping,
	input wire logic calibrating
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	logic wrClr;
	logic wrCmd;
	logic statusBit;
	assign wrClr = regWrEn && regAddr == 8'h63;
	assign wrCmd = regWrEn && regAddr == 8'h62 && !cmdBusy;
	assign statusBit = regWrData[5];
	temp_upper_zero_a: assert property (
		regRdEn && regAddr == 8'h61 |=> regRdData[7:1] == 7'h00)
		else $error("temperature high byte upper bits set");
	charge_time_pulse_a: assert property (
		wrClr && regWrData[4] |-> ##[1:3] clearChargeTime)
		else $error("no charge time clear pulse");
	status_pin_level_a: assert property (
		wrClr ##1 !wrClr |=> statusPinOe == !$past(statusBit, 2))
		else $error("status pin enable wrong");
	cmd_start_a: assert property (
		wrCmd && regWrData != 8'h00 |=> cmdBusy)
		else $error("command not started");
	erase_time_a: assert property (
		wrCmd && regWrData inside {8'h40, 8'h41, 8'h42, 8'h45, 8'h48}
		|=> cmdBusy [*8] ##[20:30] !cmdBusy)
		else $error("page command length wrong");
	program_time_a: assert property (
		wrCmd && regWrData == 8'h0f |-> ##[2:5] !cmdBusy)
		else $error("program byte did not finish");
	undefined_code_a: assert property (
		wrCmd && !(regWrData inside {8'h00, 8'h0f, 8'h40, 8'h41, 8'h42,
		8'h43, 8'h45, 8'h48, 8'hf6, 8'hf7}) |-> ##[1:4] !cmdBusy)
		else $error("unknown code not dropped");
	wake_edge_a: assert property (
		sleeping && $changed(hostLine) |-> ##[1:8] !sleeping)
		else $error("no wake on line change");
	cal_abort_a: assert property (
		calibrating && $changed(hostLine)
		|-> (!sleeping throughout (##[1:20] !cmdBusy)))
		else $error("slept after aborted calibration");
	cover property ($rose(sleeping));
	cover property ($rose(calibrating));
	cover property (wrCmd && regWrData == 8'h40 ##1 cmdBusy);
endmodule

bind gcf_control_regs gcf_regs_props #(.CAL_CYCLES(CAL_CYCLES))
	gcf_regs_props_i (.mclk(mclk), .resetn(resetn), .regAddr(regAddr),
	.regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
	.regRdData(regRdData), .hostLine(hostLine), .statusPinOe(statusPinOe),
	.clearChargeTime(clearChargeTime), .cmdBusy(cmdBusy),
	.sleeping(sleeping), .calibrating(calibrating));

// [tb_top.sv]
// Self-checking bench for the clear, command and temperature registers.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ps
module tb_top;
	logic mclk = 1'b0, resetn = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
	logic senseBelowWake = 1'b0, porDetect = 1'b0, toggleReq = 1'b0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
	logic [8:0] tempSense = 9'h000;
	logic [2:0] wakeEnableBits = 3'h7;
	logic regRdValid, hostLine, statusPinOut, statusPinOe, cmdBusy;
	logic sleeping, calibrating;
	logic [4:0] pulses;
	logic [5:0] seen = 6'h00;
	logic [7:0] codes [4] = '{8'h40, 8'h41, 8'h42, 8'h43};
	logic [7:0] addrs [4] = '{8'h05, 8'h25, 8'h45, 8'h76};
	int numErrors = 0, nCompared = 0, i;
	// ------------------------------------------------------------
	// Clock, parts and tasks
	// ------------------------------------------------------------
	always #5 mclk = !mclk;
	always @(posedge mclk) seen <= seen | {sleeping, pulses};
	gcf_host_model gcf_host_model_i (.mclk(mclk), .resetn(resetn),
		.toggleReq(toggleReq), .hostLine(hostLine));
	gcf_control_regs #(.CAL_CYCLES(8)) gcf_control_regs_i (.mclk(mclk),
		.resetn(resetn), .regAddr(regAddr), .regWrEn(regWrEn),
		.regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
		.regRdValid(regRdValid), .tempSense(tempSense),
		.senseBelowWake(senseBelowWake), .wakeEnableBits(wakeEnableBits),
		.porDetect(porDetect), .hostLine(hostLine),
		.statusPinOut(statusPinOut), .statusPinOe(statusPinOe),
		.clearChargeTime(pulses[4]), .clearDischargeTime(pulses[3]),
		.clearSelfDischarge(pulses[2]), .clearChargeCount(pulses[1]),
		.clearDischargeCount(pulses[0]), .cmdBusy(cmdBusy),
		.sleeping(sleeping), .calibrating(calibrating));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		nCompared++;
		if (got !== exp) begin
			numErrors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(negedge mclk);
		regWrEn = 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(negedge mclk);
		regRdEn = 1'b1;
		regAddr = a;
		@(negedge mclk);
		regRdEn = 1'b0;
		chk({7'h00, regRdValid}, 8'h01);
		chk(regRdData, e);
	endtask
	task automatic idle();
		for (int k = 0; k < 300 && cmdBusy !== 1'b0; k++) @(negedge mclk);
		chk({7'h00, cmdBusy}, 8'h00);
	endtask
	task automatic toggle();
		toggleReq = 1'b1;
		@(negedge mclk);
		toggleReq = 1'b0;
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Tests need about 330 cycles; allow about ninety times that
	initial begin
		#300000;
		numErrors++;
		give_verdict();
	end
	initial begin
		repeat (5) @(negedge mclk);
		resetn = 1'b1;
		chk({7'h00, statusPinOe}, 8'h00);
		chk({7'h00, statusPinOut}, 8'h00);
		rdc(8'h63, 8'h60);
		for (i = 0; i < 5; i++) begin
			seen = 6'h00;
			wr(8'h63, 8'h60 | (8'h01 << i));
			repeat (4) @(negedge mclk);
			chk({3'h0, seen[4:0]}, 8'h01 << i);
			rdc(8'h63, 8'h60);
		end
		wr(8'h63, 8'h00);
		repeat (2) @(negedge mclk);
		chk({7'h00, statusPinOe}, 8'h01);
		rdc(8'h63, 8'h00);
		porDetect = 1'b1;
		repeat (4) @(negedge mclk);
		porDetect = 1'b0;
		rdc(8'h63, 8'h40);
		wr(8'h63, 8'h60);
		tempSense = 9'h1a5;
		repeat (4) @(negedge mclk);
		rdc(8'h60, 8'ha5);
		wr(8'h61, 8'hfe);
		rdc(8'h61, 8'h01);
		$display("test clear and temperature done");
		for (i = 0; i < 4; i++) begin
			wr(8'h62, codes[i]);
			idle();
			rdc(addrs[i], 8'hff);
		end
		wr(8'h70, 8'h25);
		wr(8'h6f, 8'ha5);
		wr(8'h62, 8'h0f);
		idle();
		rdc(8'h25, 8'ha5);
		wr(8'h6f, 8'h3c);
		wr(8'h62, 8'h0f);
		idle();
		rdc(8'h25, 8'h24);
		wr(8'h83, 8'h5a);
		wr(8'h62, 8'h45);
		idle();
		rdc(8'h03, 8'h5a);
		wr(8'h83, 8'h00);
		wr(8'h62, 8'h48);
		idle();
		rdc(8'h83, 8'h5a);
		wr(8'h62, 8'h01);
		idle();
		rdc(8'hc0, 8'h00);
		$display("test flash commands done");
		wakeEnableBits = 3'h0;
		wr(8'h62, 8'hf6);
		repeat (10) @(negedge mclk);
		chk({7'h00, sleeping}, 8'h01);
		toggle();
		idle();
		chk({7'h00, sleeping}, 8'h00);
		wakeEnableBits = 3'h7;
		senseBelowWake = 1'b1;
		seen = 6'h00;
		wr(8'h62, 8'hf7);
		for (i = 0; i < 50 && calibrating !== 1'b1; i++) @(negedge mclk);
		chk({7'h00, calibrating}, 8'h01);
		toggle();
		idle();
		chk({7'h00, seen[5]}, 8'h00);
		$display("test power commands done");
		give_verdict();
	end
endmodule
